//--- logic/prmd_pkg.sv
// Shared constants, register offsets and carrier types of the paged register map
package prmd_pkg;

    // ------------------------------------------------------------------
    // Word and field sizes
    // ------------------------------------------------------------------
    localparam int unsigned WORD_W = 16;
    localparam int unsigned PAGE_W = 4;
    localparam int unsigned IDX_W = 6;
    localparam int unsigned RESULT_DEPTH = 16;
    localparam int unsigned CTRL_DEPTH = 128;

    // ------------------------------------------------------------------
    // Page codes
    // ------------------------------------------------------------------
    localparam logic [3:0] PAGE_RESULT = 4'h0;
    localparam logic [3:0] PAGE_TSC_CTRL = 4'h1;
    localparam logic [3:0] PAGE_AUDIO_CTRL = 4'h2;
    localparam logic [3:0] PAGE_BUFFER = 4'h3;

    // ------------------------------------------------------------------
    // Page 0 result register offsets
    // ------------------------------------------------------------------
    localparam logic [5:0] X_POSITION_RESULT = 6'h00;
    localparam logic [5:0] Y_POSITION_RESULT = 6'h01;
    localparam logic [5:0] FIRST_PRESSURE_RESULT = 6'h02;
    localparam logic [5:0] SECOND_PRESSURE_RESULT = 6'h03;
    localparam logic [5:0] BATTERY_RESULT = 6'h05;
    localparam logic [5:0] AUX_INPUT_ONE_RESULT = 6'h07;
    localparam logic [5:0] AUX_INPUT_TWO_RESULT = 6'h08;
    localparam logic [5:0] TEMPERATURE_FIRST_RESULT = 6'h09;
    localparam logic [5:0] TEMPERATURE_SECOND_RESULT = 6'h0a;
    // One bit per implemented result offset, reserved offsets clear
    localparam logic [15:0] RESULT_PRESENT = 16'h07af;

    // ------------------------------------------------------------------
    // Page 1 control register with split read and write meaning
    // ------------------------------------------------------------------
    localparam logic [5:0] TSC_ADC_CTRL_IDX = 6'h00;
    localparam int unsigned PEN_STATUS_BIT = 15;
    localparam int unsigned ADC_IDLE_BIT = 14;

    // ------------------------------------------------------------------
    // Fixed words and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] PAST_END_WORD = 16'hffff;
    localparam logic [15:0] RESERVED_WORD = 16'h0000;
    localparam logic [5:0] IDX_LAST = 6'h3f;

    // ------------------------------------------------------------------
    // Serial framing counts (bit counter value at the sampled bit)
    // ------------------------------------------------------------------
    localparam logic [3:0] CMD_ADDR_DONE = 4'ha;
    localparam logic [3:0] WORD_LAST_BIT = 4'hf;
    localparam logic [3:0] WORD_FIRST_BIT = 4'h0;

    // Command word bits 15..5: direction, page, register index
    typedef struct packed {
        logic is_read;
        logic [3:0] page;
        logic [5:0] index;
    } prmd_cmd_t;

    // Converter result write port
    typedef struct packed {
        logic valid;
        logic [3:0] index;
        logic [15:0] value;
    } prmd_result_t;

endpackage : prmd_pkg

//--- logic/prmd_register_map.sv
// Paged register map and address decode behind the serial register port
// Overview of operation
// - every register is sixteen bits; reads and writes move whole words
// - three decoded pages: results and two control pages; buffer page 3 reads as reserved
// - reset clears all page 0 result registers to zero
// - page 0 results are read-only; host writes never change them
// - a control bit reads back status while its written value drives control
// - command word: bit 15 direction, 14..11 page, 10..5 register, 4..0 zero
// - address advances per word; reads past page end return all ones
// - only page codes 0 to 2 decode; others, including 3, are reserved
module prmd_register_map
    import prmd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso_out,
    output logic miso_oe,
    input wire prmd_result_t result,
    input wire logic pen_down,
    input wire logic adc_idle,
    output logic [15:0] tsc_adc_ctrl,
    output logic [3:0] page_sel,
    output logic [5:0] reg_index
);

    // ------------------------------------------------------------------
    // Link side and crossing
    // ------------------------------------------------------------------
    prmd_cmd_t cmd;
    logic cmd_tgl;
    logic wr_tgl;
    logic rd_tgl;
    logic [15:0] wr_data;
    logic [15:0] rd_word;
    logic [2:0] tgl_in;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] seen;
    logic [2:0] event_hit;
    logic [2:0] next_seen;
    logic ev_cmd;
    logic ev_wr;
    logic ev_rd;

    prmd_spi_link u_link (
        .sclk(sclk),
        .rst(rst),
        .ss_n(ss_n),
        .mosi(mosi),
        .miso_out(miso_out),
        .miso_oe(miso_oe),
        .rd_word(rd_word),
        .cmd(cmd),
        .cmd_tgl(cmd_tgl),
        .wr_data(wr_data),
        .wr_tgl(wr_tgl),
        .rd_tgl(rd_tgl)
    );

    assign tgl_in = {rd_tgl, wr_tgl, cmd_tgl};

    // Toggle events count once the second and third stages agree
    always_comb begin
        event_hit = ~(sync2 ^ sync3) & (sync3 ^ seen);
        next_seen = seen ^ event_hit;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
            seen <= 3'h0;
        end else begin
            sync1 <= tgl_in;
            sync2 <= sync1;
            sync3 <= sync2;
            seen <= next_seen;
        end
    end

    assign ev_cmd = event_hit[0];
    assign ev_wr = event_hit[1];
    assign ev_rd = event_hit[2];

    // ------------------------------------------------------------------
    // Register storage and address pointer
    // ------------------------------------------------------------------
    logic [15:0] res_mem [RESULT_DEPTH];
    logic [15:0] ctl_mem [CTRL_DEPTH];
    logic [15:0] next_res_mem [RESULT_DEPTH];
    logic [15:0] next_ctl_mem [CTRL_DEPTH];
    logic [3:0] page;
    logic [5:0] idx;
    logic past_end;
    logic [3:0] next_page;
    logic [5:0] next_idx;
    logic next_past_end;
    logic [15:0] next_rd_word;
    logic [3:0] lk_page;
    logic [5:0] lk_idx;
    logic lk_past;
    logic [15:0] lk_word;
    logic step_wrap;
    logic [6:0] ctl_addr;
    logic [6:0] lk_ctl_addr;

    // Look-up target: new command address, or the next word of a read
    always_comb begin
        lk_page = page;
        lk_idx = idx + 6'h01;
        lk_past = past_end || (idx == IDX_LAST);
        if (ev_cmd) begin
            lk_page = cmd.page;
            lk_idx = cmd.index;
            lk_past = 1'b0;
        end
    end

    assign lk_ctl_addr = {lk_page == PAGE_AUDIO_CTRL, lk_idx};

    // Word decode for the look-up target
    always_comb begin
        lk_word = RESERVED_WORD;
        if (lk_past) begin
            lk_word = PAST_END_WORD;
        end else begin
            unique case (lk_page)
                PAGE_RESULT: begin
                    if ((lk_idx < 6'(RESULT_DEPTH)) && RESULT_PRESENT[lk_idx[3:0]]) begin
                        lk_word = res_mem[lk_idx[3:0]];
                    end
                end
                PAGE_TSC_CTRL, PAGE_AUDIO_CTRL: begin
                    lk_word = ctl_mem[lk_ctl_addr];
                    if ((lk_page == PAGE_TSC_CTRL) && (lk_idx == TSC_ADC_CTRL_IDX)) begin
                        lk_word[PEN_STATUS_BIT] = pen_down;
                        lk_word[ADC_IDLE_BIT] = adc_idle;
                    end
                end
                default: begin
                    lk_word = RESERVED_WORD;
                end
            endcase
        end
    end

    assign step_wrap = (idx == IDX_LAST);
    assign ctl_addr = {page == PAGE_AUDIO_CTRL, idx};

    // Pointer, read word and storage next values
    always_comb begin
        next_page = page;
        next_idx = idx;
        next_past_end = past_end;
        next_rd_word = rd_word;
        next_res_mem = res_mem;
        next_ctl_mem = ctl_mem;
        if (result.valid) begin
            next_res_mem[result.index] = result.value;
        end
        if (ev_cmd) begin
            next_page = cmd.page;
            next_idx = cmd.index;
            next_past_end = 1'b0;
            next_rd_word = lk_word;
        end else if (ev_rd) begin
            next_idx = idx + 6'h01;
            next_past_end = lk_past;
            next_rd_word = lk_word;
        end else if (ev_wr) begin
            if (!past_end && ((page == PAGE_TSC_CTRL) || (page == PAGE_AUDIO_CTRL))) begin
                next_ctl_mem[ctl_addr] = wr_data;
            end
            next_idx = idx + 6'h01;
            next_past_end = past_end || step_wrap;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            page <= PAGE_RESULT;
            idx <= 6'h00;
            past_end <= 1'b0;
            rd_word <= RESERVED_WORD;
            for (int i = 0; i < RESULT_DEPTH; i++) begin
                res_mem[i] <= RESULT_RESET;
            end
            for (int j = 0; j < CTRL_DEPTH; j++) begin
                ctl_mem[j] <= CTRL_RESET;
            end
        end else begin
            page <= next_page;
            idx <= next_idx;
            past_end <= next_past_end;
            rd_word <= next_rd_word;
            res_mem <= next_res_mem;
            ctl_mem <= next_ctl_mem;
        end
    end

    // ------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------
    // written value drives control
    assign tsc_adc_ctrl = ctl_mem[{1'b0, TSC_ADC_CTRL_IDX}];
    assign page_sel = page;
    assign reg_index = idx;

endmodule : prmd_register_map

//--- logic/prmd_spi_link.sv
// Serial-clock side of the register port: shifts command and data words
module prmd_spi_link
    import prmd_pkg::*;
(
    input wire logic sclk,
    input wire logic rst,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso_out,
    output logic miso_oe,
    input wire logic [15:0] rd_word,
    output prmd_cmd_t cmd,
    output logic cmd_tgl,
    output logic [15:0] wr_data,
    output logic wr_tgl,
    output logic rd_tgl
);

    logic [3:0] bit_cnt;
    logic [15:0] in_sh;
    logic in_cmd;
    logic [15:0] out_sh;
    logic [3:0] next_bit_cnt;
    logic [15:0] next_in_sh;
    logic next_in_cmd;
    logic [15:0] next_out_sh;
    prmd_cmd_t next_cmd;
    logic next_cmd_tgl;
    logic [15:0] next_wr_data;
    logic next_wr_tgl;
    logic next_rd_tgl;
    logic load_word;

    // ------------------------------------------------------------------
    // Receive framing, restarted by each select release
    // ------------------------------------------------------------------
    always_comb begin
        next_in_sh = {in_sh[14:0], mosi};
        next_bit_cnt = bit_cnt + 4'h1;
        next_in_cmd = in_cmd && (bit_cnt != WORD_LAST_BIT);
    end

    // Sample on the falling edge, select high holds the frame idle
    always_ff @(negedge sclk or posedge ss_n) begin
        if (ss_n) begin
            bit_cnt <= WORD_FIRST_BIT;
            in_sh <= RESERVED_WORD;
            in_cmd <= 1'b1;
        end else begin
            bit_cnt <= next_bit_cnt;
            in_sh <= next_in_sh;
            in_cmd <= next_in_cmd;
        end
    end

    // Command and write-data capture with toggle events to the core
    always_comb begin
        next_cmd = cmd;
        next_cmd_tgl = cmd_tgl;
        next_wr_data = wr_data;
        next_wr_tgl = wr_tgl;
        if (in_cmd && (bit_cnt == CMD_ADDR_DONE)) begin
            next_cmd = prmd_cmd_t'(next_in_sh[10:0]);
            next_cmd_tgl = ~cmd_tgl;
        end
        if (!in_cmd && (bit_cnt == WORD_LAST_BIT) && !cmd.is_read) begin
            next_wr_data = next_in_sh;
            next_wr_tgl = ~wr_tgl;
        end
    end

    always_ff @(negedge sclk or posedge rst) begin
        if (rst) begin
            cmd <= '0;
            cmd_tgl <= 1'b0;
            wr_data <= RESERVED_WORD;
            wr_tgl <= 1'b0;
        end else begin
            cmd <= next_cmd;
            cmd_tgl <= next_cmd_tgl;
            wr_data <= next_wr_data;
            wr_tgl <= next_wr_tgl;
        end
    end

    // ------------------------------------------------------------------
    // Transmit: load a read word at its first rising edge, then shift
    // ------------------------------------------------------------------
    assign load_word = !in_cmd && (bit_cnt == WORD_FIRST_BIT) && cmd.is_read;

    always_comb begin
        next_out_sh = {out_sh[14:0], 1'b0};
        next_rd_tgl = rd_tgl;
        if (load_word) begin
            next_out_sh = rd_word;
            next_rd_tgl = ~rd_tgl;
        end
    end

    always_ff @(posedge sclk or posedge ss_n) begin
        if (ss_n) begin
            out_sh <= RESERVED_WORD;
        end else begin
            out_sh <= next_out_sh;
        end
    end

    always_ff @(posedge sclk or posedge rst) begin
        if (rst) begin
            rd_tgl <= 1'b0;
        end else begin
            rd_tgl <= next_rd_tgl;
        end
    end

    // Output pin driven only while selected
    assign miso_out = out_sh[15];
    assign miso_oe = ~ss_n;

endmodule : prmd_spi_link

//--- sim/prmd_host_model.sv
// Serial bus master model that frames command and data words
module prmd_host_model (
    output logic sclk,
    output logic ss_n,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus, clock low outside frames
    initial begin
        sclk = 1'b0;
        ss_n <= 1'b1; // Late update so the framing reset sees a rising edge
        mosi = 1'b0;
    end

    // Select falls to open a frame
    task frame_open();
        ss_n = 1'b0;
        #10;
    endtask : frame_open

    task xfer(input logic [15:0] tx, output logic [15:0] rx);
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b1;
            mosi = tx[i];
            #6;
            sclk = 1'b0;
            rx[i] = miso;
            #6;
        end
    endtask : xfer

    // Release select; data line shows inverse of last bit
    task frame_close();
        ss_n = 1'b1;
        mosi = ~mosi;
        #30;
    endtask : frame_close
endmodule : prmd_host_model

//--- sim/prmd_register_map_asserts.sv
// Port-level assertions for the paged register map
module prmd_register_map_asserts
    import prmd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic miso_out,
    input wire logic miso_oe,
    input wire prmd_result_t result,
    input wire logic pen_down,
    input wire logic adc_idle,
    input wire logic [15:0] tsc_adc_ctrl,
    input wire logic [3:0] page_sel,
    input wire logic [5:0] reg_index
);
    default clocking cb @(posedge clk); endclocking

    logic [3:0] idle_cnt;
    logic [3:0] next_idle_cnt;
    // Clk cycles since select released, saturating
    always_comb begin
        next_idle_cnt = idle_cnt;
        if (!ss_n) begin
            next_idle_cnt = 4'h0;
        end else if (idle_cnt != 4'hf) begin
            next_idle_cnt = idle_cnt + 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            idle_cnt <= 4'h0;
        end else begin
            idle_cnt <= next_idle_cnt;
        end
    end

    oe_follow_a: assert property (disable iff (rst) miso_oe == !ss_n)
        else $error("miso enable not following select");
    idle_low_a: assert property (disable iff (rst) ss_n |-> !miso_out)
        else $error("miso not low while deselected");
    rst_ctrl_a: assert property (rst |=> tsc_adc_ctrl == CTRL_RESET)
        else $error("control word not cleared by reset");
    rst_ptr_a: assert property (rst |=> page_sel == PAGE_RESULT && reg_index == 6'h00)
        else $error("pointers not cleared by reset");
    ctrl_page_a: assert property (disable iff (rst)
        $changed(tsc_adc_ctrl) |-> page_sel == PAGE_TSC_CTRL)
        else $error("control word changed outside its page");
    ptr_frame_a: assert property (disable iff (rst) $changed(page_sel) |-> !ss_n)
        else $error("page changed outside a frame");
    ctrl_quiet_a: assert property (disable iff (rst)
        idle_cnt > 4'h8 |-> $stable(tsc_adc_ctrl))
        else $error("control word changed while idle");
    ptr_quiet_a: assert property (disable iff (rst)
        idle_cnt > 4'h8 |-> $stable(reg_index))
        else $error("index moved while idle");
endmodule : prmd_register_map_asserts

bind prmd_register_map prmd_register_map_asserts u_chk (.clk, .rst, .sclk, .ss_n, .mosi,
    .miso_out, .miso_oe, .result, .pen_down, .adc_idle, .tsc_adc_ctrl, .page_sel, .reg_index);

//--- sim/prmd_register_map_tb_top.sv
// Self-checking bench for the paged register map
module prmd_register_map_tb_top
    import prmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst, sclk, ss_n, mosi, miso_out, miso_oe, miso_w, pen_down, adc_idle;
    prmd_result_t result;
    logic [15:0] tsc_adc_ctrl;
    logic [3:0] page_sel;
    logic [5:0] reg_index;
    logic [15:0] res_q [$];
    int error_cnt = 0;
    int samples_checked = 0;

    // Undriven miso shows the inverse of miso_out
    assign miso_w = miso_oe ? miso_out : ~miso_out;

    prmd_register_map uut (.clk(clk), .rst(rst), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
        .miso_out(miso_out), .miso_oe(miso_oe), .result(result), .pen_down(pen_down),
        .adc_idle(adc_idle), .tsc_adc_ctrl(tsc_adc_ctrl), .page_sel(page_sel),
        .reg_index(reg_index));
    prmd_host_model host (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso_w));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    function automatic logic [15:0] cmd_word(logic rd, logic [3:0] pg, logic [5:0] ix);
        return {rd, pg, ix, 5'h00};
    endfunction : cmd_word

    task rd_words(input logic [3:0] pg, input logic [5:0] ix, input logic [15:0] exp [$]);
        logic [15:0] rx;
        host.frame_open();
        host.xfer(cmd_word(1'b1, pg, ix), rx);
        foreach (exp[i]) begin
            host.xfer(16'h0000, rx);
            check(rx, exp[i], "read word");
        end
        host.frame_close();
    endtask : rd_words

    task wr_words(input logic [3:0] pg, input logic [5:0] ix, input logic [15:0] d [$]);
        logic [15:0] rx;
        host.frame_open();
        host.xfer(cmd_word(1'b0, pg, ix), rx);
        foreach (d[i]) host.xfer(d[i], rx);
        host.frame_close();
    endtask : wr_words

    task t_reset();
        logic [15:0] z [$];
        for (int i = 0; i < 16; i++) z.push_back(16'h0000);
        check(tsc_adc_ctrl, CTRL_RESET, "control reset");
        rd_words(PAGE_RESULT, 6'h00, z);
        $display("reset test done");
    endtask : t_reset

    task t_results();
        @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            result <= '{valid: 1'b1, index: i[3:0], value: 16'h0a10 + 16'(i)};
            res_q.push_back(RESULT_PRESENT[i] ? 16'h0a10 + 16'(i) : RESERVED_WORD);
            @(posedge clk);
        end
        result <= '0;
        rd_words(PAGE_RESULT, 6'h00, res_q);
        wr_words(PAGE_RESULT, 6'h00, '{16'hbeef, 16'hbeef, 16'hbeef});
        rd_words(PAGE_RESULT, 6'h00, res_q);
        $display("result page test done");
    endtask : t_results

    task t_ctrl();
        wr_words(PAGE_TSC_CTRL, TSC_ADC_CTRL_IDX, '{16'hc3a5});
        repeat (8) @(posedge clk);
        check(tsc_adc_ctrl, 16'hc3a5, "control output");
        rd_words(PAGE_TSC_CTRL, TSC_ADC_CTRL_IDX, '{16'h43a5});
        @(posedge clk);
        pen_down <= 1'b1;
        adc_idle <= 1'b0;
        rd_words(PAGE_TSC_CTRL, TSC_ADC_CTRL_IDX, '{16'h83a5});
        $display("control test done");
    endtask : t_ctrl

    task t_page_end();
        wr_words(PAGE_AUDIO_CTRL, 6'h3e, '{16'h1234, 16'h5678, 16'h9abc});
        check(16'(page_sel), 16'(PAGE_AUDIO_CTRL), "page pointer");
        rd_words(PAGE_AUDIO_CTRL, 6'h3e, '{16'h1234, 16'h5678, 16'hffff, 16'hffff});
        rd_words(PAGE_AUDIO_CTRL, 6'h00, '{16'h0000});
        check(16'(reg_index), 16'h0001, "index advance");
        $display("page end test done");
    endtask : t_page_end

    task t_reserved();
        for (int p = 3; p < 16; p++) begin
            wr_words(p[3:0], 6'h01, '{16'ha5a5});
            rd_words(p[3:0], 6'h01, '{RESERVED_WORD});
        end
        rd_words(PAGE_TSC_CTRL, 6'h01, '{16'h0000});
        rd_words(PAGE_AUDIO_CTRL, 6'h3e, '{16'h1234});
        $display("reserved page test done");
    endtask : t_reserved

    // Reset in mid-run after results and control words were written
    task t_reset_again();
        logic [15:0] z [$];
        for (int i = 0; i < 16; i++) z.push_back(RESULT_RESET);
        @(posedge clk);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        check(tsc_adc_ctrl, CTRL_RESET, "control after reset");
        rd_words(PAGE_RESULT, 6'h00, z);
        rd_words(PAGE_AUDIO_CTRL, 6'h3e, '{CTRL_RESET});
        $display("second reset test done");
    endtask : t_reset_again

    task test_done();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        rst <= 1'b1; // Late update so the link's reset sees a rising edge
        result = '0;
        pen_down = 1'b0;
        adc_idle = 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_reset();
        t_results();
        t_ctrl();
        t_page_end();
        t_reserved();
        t_reset_again();
        test_done();
    end

    // Watchdog against a hung frame
    initial begin
        repeat (30000) @(posedge clk);
        error_cnt++;
        test_done();
    end
endmodule : prmd_register_map_tb_top
